/* File: hdl/vpm_pkg.sv */
// Shared constants for the legacy palette and indexed window register block
package vpm_pkg;
    // ==========================================================
    // Host I/O port addresses
    localparam logic [15:0] PORT_ATTR_INDEX = 16'h03C0;
    localparam logic [15:0] PORT_ATTR_DATA_RD = 16'h03C1;
    localparam logic [15:0] PORT_PIXEL_MASK = 16'h03C6;
    localparam logic [15:0] PORT_READ_POINTER = 16'h03C7;
    localparam logic [15:0] PORT_WRITE_POINTER = 16'h03C8;
    localparam logic [15:0] PORT_PALETTE_DATA = 16'h03C9;
    localparam logic [15:0] PORT_EXT_INDEX = 16'h03D4;
    localparam logic [15:0] PORT_EXT_DATA = 16'h03D5;
    localparam logic [15:0] PORT_INPUT_STATUS = 16'h03DA;
    // ==========================================================
    // Attribute register indexes
    localparam logic [4:0] ATTR_MODE_CTRL = 5'h10;
    localparam logic [4:0] ATTR_HPAN = 5'h13;
    localparam logic [4:0] ATTR_COLOUR_SEL = 5'h14;
    // Attribute mode control field positions
    localparam int MODE_GRAPHICS_BIT = 0;
    localparam int MODE_256_BIT = 6;
    localparam int MODE_VIDSEL_BIT = 7;
    // Attribute index field positions
    localparam int ATTR_PAS_BIT = 5;
    // ==========================================================
    // Extended window indexes
    localparam logic [7:0] EXT_BR_ADDR0 = 8'h80;
    localparam logic [7:0] EXT_BR_ADDR1 = 8'h81;
    localparam logic [7:0] EXT_BR_ADDR2 = 8'h82;
    localparam logic [7:0] EXT_BR_DATA0 = 8'h84;
    localparam logic [7:0] EXT_BR_DATA1 = 8'h85;
    localparam logic [7:0] EXT_BR_DATA2 = 8'h86;
    localparam logic [7:0] EXT_BR_DATA3 = 8'h87;
    localparam logic [7:0] EXT_CONFIG = 8'h88;
    localparam logic [7:0] EXT_PAGE_LOW = 8'h89;
    localparam logic [7:0] EXT_PAGE_HIGH = 8'h8A;
    localparam logic [7:0] EXT_SCRATCH_FIRST = 8'h8B;
    localparam logic [7:0] EXT_SCRATCH_LAST = 8'h9F;
    localparam int SCRATCH_COUNT = 21;
    // Configuration field positions
    localparam int CFG_NATIVE_BIT = 1;
    localparam int CFG_APERTURE_BIT = 2;
    localparam int CFG_USER_LSB = 4;
    // ==========================================================
    // Reset values
    localparam logic [7:0] PIXEL_MASK_RESET = 8'hFF;
    localparam logic [1:0] PAL_CTL_RESET = 2'h0;
    // Palette RAM output control codes
    localparam logic [1:0] PAL_CTL_POINTER = 2'h3;
    localparam logic [1:0] PAL_CTL_DATA = 2'h1;
    // Palette status codes
    localparam logic [1:0] PAL_STATE_WRITE = 2'h0;
    localparam logic [1:0] PAL_STATE_READ = 2'h3;
    // Byte position of the last byte of a palette entry
    localparam logic [1:0] PAL_LAST_BYTE = 2'h2;
    // ==========================================================
    // Host access sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACK = 4'b0010,
        ST_BR_READ = 4'b0100,
        ST_BR_WRITE = 4'b1000
    } vpm_state_e;
endpackage : vpm_pkg

/* File: hdl/vpm_dac.sv */
// Palette DAC: pointer sequencing, colour lookup table and pixel lookup
`timescale 1ns/1ps
module vpm_dac #(
    parameter int ENTRIES = 256
) (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic set_read_ptr, // Pulse: read pointer written
    input wire logic set_write_ptr, // Pulse: write pointer written
    input wire logic data_write, // Pulse: data port written
    input wire logic data_read, // Pulse: data port read
    input wire logic [7:0] host_byte, // Host write byte
    output logic [7:0] palette_byte_field, // Byte the data port returns
    output logic [7:0] write_index_field, // Current write pointer
    output logic [1:0] palette_state_field, // Read or write sequence status
    input wire logic [7:0] lookup_index, // Masked pixel index
    output logic [23:0] dac_rgb // Registered lookup result
);
    import vpm_pkg::*;

    // ==========================================================
    // Storage and sequence state
    logic [23:0] lut [ENTRIES];
    logic [7:0] read_index_field;
    logic [1:0] byte_sel;
    logic reading;
    logic [15:0] held_bytes;
    logic [23:0] rd_entry;

    // Entry under the read pointer, split by byte position
    assign rd_entry = lut[read_index_field];
    assign palette_byte_field = (byte_sel == 2'h0) ? rd_entry[23:16] :
                                (byte_sel == 2'h1) ? rd_entry[15:8] : rd_entry[7:0];
    assign palette_state_field = reading ? PAL_STATE_READ : PAL_STATE_WRITE;

    // Pointer and byte-count sequencing of the data port
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            read_index_field <= 8'h00;
            write_index_field <= 8'h00;
            byte_sel <= 2'h0;
            reading <= 1'b0;
            held_bytes <= 16'h0000;
        end else if (set_read_ptr) begin
            read_index_field <= host_byte;
            byte_sel <= 2'h0;
            reading <= 1'b1;
        end else if (set_write_ptr) begin
            write_index_field <= host_byte;
            byte_sel <= 2'h0;
            reading <= 1'b0;
        end else if (data_read || data_write) begin
            // Third byte ends the entry and advances the pointer
            if (byte_sel == PAL_LAST_BYTE) begin
                byte_sel <= 2'h0;
                if (reading) begin
                    read_index_field <= read_index_field + 8'h01;
                end else begin
                    write_index_field <= write_index_field + 8'h01;
                end
            end else begin
                byte_sel <= byte_sel + 2'h1;
                held_bytes <= {held_bytes[7:0], host_byte};
            end
        end
    end

    // Table write on the third byte of a write sequence, no reset on the RAM
    always_ff @(posedge clk_sys) begin
        if (data_write && !reading && byte_sel == PAL_LAST_BYTE) begin
            lut[write_index_field] <= {held_bytes, host_byte};
        end
    end

    // Pixel lookup, one cycle of latency
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dac_rgb <= 24'h000000;
        end else begin
            dac_rgb <= lut[lookup_index];
        end
    end
endmodule : vpm_dac

/* File: hdl/vpm_regs.sv */
// Legacy display register block: attribute, palette and indexed window ports
`timescale 1ns/1ps
module vpm_regs (
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic io_req, // Host I/O request, held until io_ready
    input wire logic io_wr, // 1 write, 0 read
    input wire logic [15:0] io_addr, // Host I/O port address
    input wire logic [7:0] io_wdata, // Host write byte
    output logic io_ready, // One-cycle completion strobe
    output logic [7:0] io_rdata, // Read byte, valid with io_ready
    output logic mm_req, // Bridged cycle request, held until mm_ack
    output logic mm_we, // Bridged cycle is a write
    output logic [23:0] mm_addr, // Bridged cycle address
    output logic [31:0] mm_wdata, // Bridged write word
    input wire logic mm_ack, // Bridged cycle done
    input wire logic [31:0] mm_rdata, // Bridged read word, valid with mm_ack
    input wire logic aperture_strap_pin, // Aperture mode strap
    input wire logic [1:0] user_strap, // User configuration straps
    input wire logic char_nine_dot, // Nine-dot character clock selected
    input wire logic [7:0] pixel_in, // 256-colour pixel byte
    input wire logic [5:0] attr_colour, // Attribute palette output
    input wire logic [15:0] legacy_addr, // Legacy frame address
    output logic [25:0] local_mem_addr, // Paged local memory address
    output logic legacy_addr_en, // Legacy paging in force
    output logic linear_aperture, // 1 panel clock and linear aperture
    output logic native_mode, // 1 native graphics mode
    output logic attr_palette_enable, // Normal video translation enabled
    output logic [3:0] pan_shift_px, // Left shift in pixels
    output logic [1:0] pal_ctl_code, // Palette RAM output control
    output logic [23:0] dac_rgb // Colour lookup result
);
    import vpm_pkg::*;

    // ==========================================================
    // State
    vpm_state_e state;
    vpm_state_e next_state;
    logic attr_data_phase;
    logic [5:0] attr_index;
    logic [7:0] attr_mode;
    logic [3:0] pan_shift_code;
    logic [1:0] colour_msb_pair;
    logic [1:0] colour_mid_pair;
    logic [7:0] pixel_mask_field;
    logic [7:0] ext_index;
    logic [23:0] bridge_addr;
    logic [31:0] bridge_data;
    logic strap_done;
    logic cfg_aperture;
    logic cfg_native;
    logic [1:0] cfg_user;
    logic [9:0] page_base_field;
    logic [7:0] scratch [SCRATCH_COUNT];

    // ==========================================================
    // Pan decode per character width and colour mode
    function automatic logic [3:0] pan_decode(input logic [3:0] code, input logic nine,
                                              input logic text, input logic c256);
        logic [3:0] px;
        px = 4'h0;
        if (c256) begin
            // Bit 0 is ignored, so odd codes pan as the even code below
            px = code[3] ? 4'h0 : {2'b00, code[2:1]};
        end else if (nine && text) begin
            px = code[3] ? 4'h0 : code + 4'h1;
        end else begin
            px = code[3] ? 4'h0 : code;
        end
        return px;
    endfunction : pan_decode

    // ==========================================================
    // Request decode
    wire take = (state == ST_IDLE) && io_req;
    wire take_wr = take && io_wr;
    wire take_rd = take && !io_wr;
    wire hit_attr = (io_addr == PORT_ATTR_INDEX);
    wire hit_attr_rd = (io_addr == PORT_ATTR_DATA_RD);
    wire hit_mask = (io_addr == PORT_PIXEL_MASK);
    wire hit_rptr = (io_addr == PORT_READ_POINTER);
    wire hit_wptr = (io_addr == PORT_WRITE_POINTER);
    wire hit_pdata = (io_addr == PORT_PALETTE_DATA);
    wire hit_xidx = (io_addr == PORT_EXT_INDEX);
    wire hit_xdata = (io_addr == PORT_EXT_DATA);
    wire hit_status = (io_addr == PORT_INPUT_STATUS);
    wire ext_is_data = (ext_index >= EXT_BR_DATA0) && (ext_index <= EXT_BR_DATA3);
    wire ext_is_scratch = (ext_index >= EXT_SCRATCH_FIRST) && (ext_index <= EXT_SCRATCH_LAST);
    wire [4:0] scratch_slot = 5'(ext_index - EXT_SCRATCH_FIRST);
    wire [1:0] data_lane = ext_index[1:0];
    wire ext_wr = take_wr && hit_xdata;
    wire br_write_go = ext_wr && (ext_index == EXT_BR_DATA0);
    wire br_read_go = take_rd && hit_xdata && ext_is_data;
    wire attr_wr = take_wr && hit_attr && attr_data_phase;

    // Palette DAC strobes
    wire dac_set_rptr = take_wr && hit_rptr;
    wire dac_set_wptr = take_wr && hit_wptr;
    wire dac_data_wr = take_wr && hit_pdata;
    wire dac_data_rd = take_rd && hit_pdata;
    wire [7:0] dac_byte;
    wire [7:0] dac_wptr;
    wire [1:0] dac_state;

    // ==========================================================
    // Colour index formation and mask
    wire mode_256 = attr_mode[MODE_256_BIT];
    wire mode_text = !attr_mode[MODE_GRAPHICS_BIT];
    wire [1:0] mid_bits = attr_mode[MODE_VIDSEL_BIT] ? colour_mid_pair : attr_colour[5:4];
    wire [7:0] formed_index = mode_256 ? pixel_in :
                              {colour_msb_pair, mid_bits, attr_colour[3:0]};
    wire [7:0] lookup_index = formed_index & pixel_mask_field;

    vpm_dac #(
        .ENTRIES(256)
    ) u_dac (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .set_read_ptr(dac_set_rptr),
        .set_write_ptr(dac_set_wptr),
        .data_write(dac_data_wr),
        .data_read(dac_data_rd),
        .host_byte(io_wdata),
        .palette_byte_field(dac_byte),
        .write_index_field(dac_wptr),
        .palette_state_field(dac_state),
        .lookup_index(lookup_index),
        .dac_rgb(dac_rgb)
    );

    // ==========================================================
    // Read data selection
    wire [7:0] cfg_byte = {2'b00, cfg_user, 1'b0, cfg_aperture, cfg_native, 1'b0};
    wire [7:0] attr_rd_byte = (attr_index[4:0] == ATTR_MODE_CTRL) ? attr_mode :
                              (attr_index[4:0] == ATTR_HPAN) ? {4'h0, pan_shift_code} :
                              (attr_index[4:0] == ATTR_COLOUR_SEL) ?
                              {4'h0, colour_msb_pair, colour_mid_pair} : 8'h00;
    wire [7:0] data_rd_byte = (data_lane == 2'h0) ? bridge_data[7:0] :
                              (data_lane == 2'h1) ? bridge_data[15:8] :
                              (data_lane == 2'h2) ? bridge_data[23:16] : bridge_data[31:24];
    wire [7:0] ext_rd_byte = (ext_index == EXT_BR_ADDR0) ? bridge_addr[7:0] :
                             (ext_index == EXT_BR_ADDR1) ? bridge_addr[15:8] :
                             (ext_index == EXT_BR_ADDR2) ? bridge_addr[23:16] :
                             ext_is_data ? data_rd_byte :
                             (ext_index == EXT_CONFIG) ? cfg_byte :
                             (ext_index == EXT_PAGE_LOW) ? page_base_field[7:0] :
                             (ext_index == EXT_PAGE_HIGH) ? {6'h00, page_base_field[9:8]} :
                             ext_is_scratch ? scratch[scratch_slot] : 8'h00;
    wire [7:0] port_rd_byte = hit_attr ? {2'b00, attr_index} :
                              hit_attr_rd ? attr_rd_byte :
                              hit_mask ? pixel_mask_field :
                              hit_rptr ? {6'h00, dac_state} :
                              hit_wptr ? dac_wptr :
                              hit_pdata ? dac_byte :
                              hit_xidx ? ext_index :
                              hit_xdata ? ext_rd_byte : 8'h00;

    // Byte of the returned bridge word that the host asked for
    wire [7:0] mm_rd_byte = (data_lane == 2'h0) ? mm_rdata[7:0] :
                            (data_lane == 2'h1) ? mm_rdata[15:8] :
                            (data_lane == 2'h2) ? mm_rdata[23:16] : mm_rdata[31:24];

    // ==========================================================
    // Host access sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (br_read_go) begin
                    next_state = ST_BR_READ;
                end else if (br_write_go) begin
                    next_state = ST_BR_WRITE;
                end else if (take) begin
                    next_state = ST_ACK;
                end
            end
            ST_ACK: begin
                next_state = ST_IDLE;
            end
            ST_BR_READ, ST_BR_WRITE: begin
                if (mm_ack) begin
                    next_state = ST_ACK;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign io_ready = (state == ST_ACK);
    assign mm_req = (state == ST_BR_READ) || (state == ST_BR_WRITE);
    assign mm_we = (state == ST_BR_WRITE);
    assign mm_addr = bridge_addr;
    assign mm_wdata = bridge_data;

    // Read byte capture: immediate for ports, on acknowledge for bridge reads
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= 8'h00;
        end else if (state == ST_BR_READ && mm_ack) begin
            io_rdata <= mm_rd_byte;
        end else if (take_rd) begin
            io_rdata <= port_rd_byte;
        end
    end

    // ==========================================================
    // Attribute port: index and data share one write port
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            attr_data_phase <= 1'b0;
            attr_index <= 6'h00;
        end else if (take_rd && hit_status) begin
            attr_data_phase <= 1'b0;
        end else if (take_wr && hit_attr) begin
            attr_data_phase <= !attr_data_phase;
            if (!attr_data_phase) begin
                attr_index <= io_wdata[5:0];
            end
        end
    end

    // Attribute registers selected by the pointer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            attr_mode <= 8'h00;
            pan_shift_code <= 4'h0;
            colour_msb_pair <= 2'b00;
            colour_mid_pair <= 2'b00;
        end else if (attr_wr) begin
            if (attr_index[4:0] == ATTR_MODE_CTRL) begin
                attr_mode <= io_wdata;
            end
            if (attr_index[4:0] == ATTR_HPAN) begin
                pan_shift_code <= io_wdata[3:0];
            end
            if (attr_index[4:0] == ATTR_COLOUR_SEL) begin
                colour_msb_pair <= io_wdata[3:2];
                colour_mid_pair <= io_wdata[1:0];
            end
        end
    end

    // Pixel mask and palette RAM output control code
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pixel_mask_field <= PIXEL_MASK_RESET;
            pal_ctl_code <= PAL_CTL_RESET;
        end else begin
            if (take_wr && hit_mask) begin
                pixel_mask_field <= io_wdata;
            end
            if (dac_set_rptr || dac_set_wptr) begin
                pal_ctl_code <= PAL_CTL_POINTER;
            end else if (dac_data_wr || dac_data_rd) begin
                pal_ctl_code <= PAL_CTL_DATA;
            end
        end
    end

    // ==========================================================
    // Indexed window: bridge, configuration and page base
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_index <= 8'h00;
            bridge_addr <= 24'h000000;
            bridge_data <= 32'h00000000;
            page_base_field <= 10'h000;
            cfg_native <= 1'b0;
        end else begin
            if (take_wr && hit_xidx) begin
                ext_index <= io_wdata;
            end
            if (state == ST_BR_READ && mm_ack) begin
                bridge_data <= mm_rdata;
            end else if (ext_wr) begin
                case (ext_index)
                    EXT_BR_ADDR0: bridge_addr[7:0] <= io_wdata;
                    EXT_BR_ADDR1: bridge_addr[15:8] <= io_wdata;
                    EXT_BR_ADDR2: bridge_addr[23:16] <= io_wdata;
                    EXT_BR_DATA0: bridge_data[7:0] <= io_wdata;
                    EXT_BR_DATA1: bridge_data[15:8] <= io_wdata;
                    EXT_BR_DATA2: bridge_data[23:16] <= io_wdata;
                    EXT_BR_DATA3: bridge_data[31:24] <= io_wdata;
                    EXT_CONFIG: cfg_native <= io_wdata[CFG_NATIVE_BIT];
                    EXT_PAGE_LOW: page_base_field[7:0] <= io_wdata;
                    EXT_PAGE_HIGH: page_base_field[9:8] <= io_wdata[1:0];
                    default: begin
                    end
                endcase
            end
            // Only a bridge read or a host write of a data byte reloads bridge_data; otherwise the bridge bytes stay for reuse
        end
    end

    // Straps are caught on the first edge after reset release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_done <= 1'b0;
            cfg_aperture <= 1'b0;
            cfg_user <= 2'b00;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            cfg_aperture <= aperture_strap_pin;
            cfg_user <= user_strap;
        end else if (ext_wr && ext_index == EXT_CONFIG) begin
            cfg_aperture <= io_wdata[CFG_APERTURE_BIT];
        end
    end

    // Scratch bytes, no reset needed
    always_ff @(posedge clk_sys) begin
        if (ext_wr && ext_is_scratch) begin
            scratch[scratch_slot] <= io_wdata;
        end
    end

    // ==========================================================
    // Outputs to the display pipeline
    assign pan_shift_px = pan_decode(pan_shift_code, char_nine_dot, mode_text, mode_256);
    assign local_mem_addr = {page_base_field, legacy_addr};
    assign legacy_addr_en = !cfg_native;
    assign native_mode = cfg_native;
    assign linear_aperture = cfg_aperture;
    assign attr_palette_enable = attr_index[ATTR_PAS_BIT];
endmodule : vpm_regs

/* File: test/vpm_regs_checker.sv */
// Assertion checker for the palette and window register block
`timescale 1ns/1ps
module vpm_regs_checker (
    input wire logic clk_sys, input wire logic arst_n, input wire logic io_wr,
    input wire logic [15:0] io_addr, input wire logic io_ready, input wire logic mm_req,
    input wire logic mm_ack, input wire logic [23:0] mm_addr, input wire logic [31:0] mm_wdata,
    input wire logic native_mode, input wire logic legacy_addr_en,
    input wire logic [15:0] legacy_addr, input wire logic [25:0] local_mem_addr,
    input wire logic [3:0] pan_shift_px, input wire logic char_nine_dot,
    input wire logic [1:0] pal_ctl_code
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_ptr_code: assert property (io_ready && io_wr && io_addr inside {16'h03C7, 16'h03C8}
        |=> pal_ctl_code == 2'h3) else $error("pointer code wrong");
    a_data_code: assert property (io_ready && io_addr == 16'h03C9
        |=> pal_ctl_code == 2'h1) else $error("data code wrong");
    a_mode_pair: assert property (native_mode != legacy_addr_en) else $error("mode pair");
    a_page_low: assert property (local_mem_addr[15:0] == legacy_addr) else $error("page");
    a_bridge_hold: assert property (mm_req && !mm_ack
        |=> mm_req && $stable(mm_addr) && $stable(mm_wdata)) else $error("bridge moved");
    a_bridge_done: assert property (mm_req && mm_ack |=> io_ready && !mm_req)
        else $error("bridge end");
    a_nine_max: assert property (pan_shift_px <= 4'h8) else $error("pan over 8");
    a_eight_max: assert property (!char_nine_dot |-> pan_shift_px <= 4'h7)
        else $error("pan over 7");
endmodule : vpm_regs_checker

/* File: test/vpm_mm_model.sv */
// Register space model answering bridged cycles
`timescale 1ns/1ps
module vpm_mm_model #(parameter logic [31:0] RD = 32'hA5C39E71) (
    input wire logic clk_sys, input wire logic mm_req, input wire logic [3:0] dly,
    output logic mm_ack = 0, output logic [31:0] mm_rdata = 0
);
    logic [3:0] n = 0;
    // Acknowledge after dly cycles, data bus toggles on every cycle without an acknowledge
    always @(posedge clk_sys) begin
        mm_ack <= 0;
        mm_rdata <= ~mm_rdata;
        if (mm_req && !mm_ack && n == dly) begin
            {mm_ack, mm_rdata, n} <= {1'h1, RD, 4'h0};
        end else if (mm_req && !mm_ack) n <= n + 4'h1;
    end
endmodule : vpm_mm_model

/* File: test/tb_vpm_regs.sv */
// Testbench for the palette and window register block
`timescale 1ns/1ps
module tb_vpm_regs;
    logic clk_sys = 0, arst_n = 0, io_req = 0, io_wr = 0, mm_ack, io_ready, mm_req, mm_we;
    logic char_nine_dot = 0, native_mode, legacy_addr_en, linear_aperture, we_seen = 0, pal_en, ap = 1;
    logic [15:0] io_addr = 0, legacy_addr = 16'hBEEF, bw [7];
    logic [7:0] io_wdata = 0, io_rdata, pixel_in = 8'hF5;
    logic [31:0] mm_rdata, mm_wdata;
    logic [23:0] mm_addr, dac_rgb;
    logic [25:0] local_mem_addr;
    logic [16:0] pt [6] = '{17'h04163, 17'h10080, 17'h10078, 17'h10001, 17'h00077, 17'h10177};
    logic [5:0] attr_colour = 6'h05;
    logic [3:0] pan_shift_px, dly = 0;
    logic [1:0] pal_ctl_code;
    int n_errors = 0, n_compared = 0, n_acks = 0;
    always #2.5 clk_sys = ~clk_sys;
    // Count bridged cycles and note the direction of the last one
    always @(posedge clk_sys) begin
        if (mm_ack) begin
            n_acks++;
            we_seen = mm_we;
        end
    end
    vpm_regs dut (.clk_sys, .arst_n, .io_req, .io_wr, .io_addr, .io_wdata, .io_ready, .io_rdata,
        .mm_req, .mm_we, .mm_addr, .mm_wdata, .mm_ack, .mm_rdata, .aperture_strap_pin(ap),
        .user_strap(2'h2), .char_nine_dot, .pixel_in, .attr_colour, .legacy_addr,
        .local_mem_addr, .legacy_addr_en, .linear_aperture, .native_mode,
        .attr_palette_enable(pal_en), .pan_shift_px, .pal_ctl_code, .dac_rgb);
    vpm_mm_model mdl (.clk_sys, .mm_req, .dly, .mm_ack, .mm_rdata);
    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One host access: hold until ready, release after the sampling edge
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        int i;
        i = 0;
        {io_req, io_wr, io_addr, io_wdata} = {1'h1, w, a, d};
        do begin
            @(posedge clk_sys);
            #1 i++;
        end while (io_ready !== 1'h1 && i < 300);
        if (i >= 300) n_errors++;
        if (i >= 300) finish_test();
        @(posedge clk_sys);
        #1 io_req = 0;
        @(posedge clk_sys);
        #1;
    endtask : io
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string s);
        io(0, a, 8'h00);
        chk(s, e, io_rdata);
    endtask : rd
    task automatic xw(input logic [7:0] i, input logic [7:0] d);
        io(1, 16'h03D4, i);
        io(1, 16'h03D5, d);
    endtask : xw
    task automatic aw(input logic [7:0] i, input logic [7:0] d);
        io(1, 16'h03C0, i | 8'h20);
        io(1, 16'h03C0, d);
    endtask : aw
    initial begin
        bw = '{16'h8056, 16'h8134, 16'h8212, 16'h8544, 16'h8633, 16'h8722, 16'h8411};
        repeat (20) @(posedge clk_sys);
        #1 arst_n = 1;
        repeat (2) @(posedge clk_sys);
        #1 rd(16'h03C6, 8'hFF, "mask");
        io(1, 16'h03C8, 8'hE5);
        chk("ctl", 2'h3, pal_ctl_code);
        rd(16'h03C7, 8'h00, "state");
        for (int k = 1; k < 4; k++) io(1, 16'h03C9, 8'(8'h11 * k));
        chk("ctl", 2'h1, pal_ctl_code);
        rd(16'h03C8, 8'hE6, "wptr");
        io(1, 16'h03C7, 8'hE5);
        rd(16'h03C7, 8'h03, "state");
        for (int k = 1; k < 4; k++) rd(16'h03C9, 8'(8'h11 * k), "entry");
        $display("palette test done");
        io(0, 16'h03DA, 8'h00);
        io(1, 16'h03C6, 8'hEF);
        aw(8'h10, 8'h41);
        chk("pas", 1, pal_en);
        chk("rgb", 24'h112233, dac_rgb);
        aw(8'h14, 8'h0E);
        aw(8'h10, 8'h81);
        chk("rgb", 24'h112233, dac_rgb);
        foreach (pt[k]) begin
            char_nine_dot = pt[k][16];
            aw(8'h10, pt[k][15:8]);
            aw(8'h13, {4'h0, pt[k][7:4]});
            chk("pan", pt[k][3:0], pan_shift_px);
        end
        rd(16'h03C1, 8'h07, "attr");
        $display("attribute test done");
        foreach (bw[k]) xw(bw[k][15:8], bw[k][7:0]);
        chk("maddr", 24'h123456, mm_addr);
        chk("mdata", 32'h22334411, mm_wdata);
        chk("acks", 1, n_acks);
        chk("we", 1, we_seen);
        dly = 4'h6;
        io(1, 16'h03D4, 8'h86);
        rd(16'h03D5, 8'hC3, "mread");
        chk("acks", 2, n_acks);
        chk("we", 0, we_seen);
        chk("maddr", 24'h123456, mm_addr);
        io(1, 16'h03D4, 8'h88);
        rd(16'h03D5, 8'h24, "cfg");
        xw(8'h88, 8'h02);
        chk("native", 1, native_mode);
        chk("linear", 0, linear_aperture);
        chk("legacy", 0, legacy_addr_en);
        xw(8'h89, 8'h5A);
        xw(8'h8A, 8'h03);
        chk("laddr", 26'h35ABEEF, local_mem_addr);
        xw(8'h90, 8'h3C);
        rd(16'h03D5, 8'h3C, "scratch");
        rd(16'h03B0, 8'h00, "unmapped");
        $display("window test done");
        // Second reset with the aperture strap low
        {ap, arst_n} = 2'h0;
        repeat (2) @(posedge clk_sys);
        #1 arst_n = 1;
        repeat (2) @(posedge clk_sys);
        #1 chk("ctl", 2'h0, pal_ctl_code);
        rd(16'h03C6, 8'hFF, "mask");
        io(1, 16'h03D4, 8'h88);
        rd(16'h03D5, 8'h20, "cfg");
        $display("reset test done");
        finish_test();
    end
endmodule : tb_vpm_regs
bind vpm_regs vpm_regs_checker chk (.clk_sys, .arst_n, .io_wr, .io_addr, .io_ready, .mm_req,
    .mm_ack, .mm_addr, .mm_wdata, .native_mode, .legacy_addr_en, .legacy_addr,
    .local_mem_addr, .pan_shift_px, .char_nine_dot, .pal_ctl_code);
